//--- hw/io_exp_pkg.sv
// package: constants and carrier structs for the I/O expansion port
// assumes: included before every design file of the port
package io_exp_pkg;

  // processor port addresses decoded inside the host
  localparam logic [7:0] EXT_IO_CTRL_PORT   = 8'hEC;
  localparam logic [7:0] INT_CTRL_PORT      = 8'hE0;
  localparam logic [7:0] INT_STATUS_PORT    = 8'hE0;
  // bit positions
  localparam int EXT_IO_ENABLE_POS          = 4;
  localparam int BUS_INT_ENABLE_POS         = 3;
  localparam int BUS_INT_STATUS_POS         = 3;
  // reset values of the two enable bits
  localparam logic EXT_IO_ENABLE_RST        = 1'b0;
  localparam logic BUS_INT_ENABLE_RST       = 1'b0;
  // lowest port number reserved for the host itself
  localparam logic [7:0] RESERVED_PORT_BASE = 8'h80;

  // processor cycle strobes, active low
  typedef struct packed {
    logic opcode_fetch_n;
    logic io_request_n;
    logic rd_n;
    logic wr_n;
  } cpu_ctl_s;

  // buffered control lines on the connector, active low
  typedef struct packed {
    logic opcode_fetch_n;
    logic io_request_n;
    logic in_strobe_n;
    logic out_strobe_n;
  } bus_ctl_s;

endpackage

//--- hw/io_exp_sync.sv
// file: two-stage synchroniser for the connector inputs
// assumes: synchronous active-high reset; inputs idle high
`timescale 1ns/1ns
`default_nettype none
module io_exp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             CLOCK,
  input  wire logic             SRST,
  input  wire logic [WIDTH-1:0] D,
  output logic      [WIDTH-1:0] Q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = D;
    q_nxt    = meta_r;
    if (SRST)
    begin
      meta_nxt = '1;
      q_nxt    = '1;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    meta_r <= meta_nxt;
    q_r    <= q_nxt;
  end

  assign Q = q_r;

endmodule
`default_nettype wire

//--- hw/io_exp_port.sv
// file: buffered I/O expansion port between processor and connector
// assumes: processor strobes arrive synchronous to CLOCK; the connector
// lines arrive asynchronously and are synchronised here; bus data
// settles while the card holds its select low
//
// Summary of operation
// - drive eight low address lines to the connector while external I/O enabled
// - eight-bit two-way data path, active only while external I/O enabled
// - buffered opcode fetch line; with I/O request marks interrupt acknowledge
// - active-low I/O request strobe on every input or output cycle
// - active-low input strobe for the whole of each input cycle
// - active-low output strobe from I/O request and write both active
// - all lines except reset and interrupt request disabled until external I/O enable bit set
// - software sets bit 4 of port 0ECH before using the bus
// - bus wait reaches processor wait only while external I/O enabled
// - bus interrupt reaches processor only while bit 3 of port 0E0H set
// - live bus interrupt state readable on port E0 regardless of enable
`timescale 1ns/1ns
`default_nettype none
module io_exp_port #(
  parameter int ADDR_WIDTH = 8,
  parameter int DATA_WIDTH = 8
) (
  input  wire logic                  CLOCK,
  input  wire logic                  SRST,
  // processor side
  input  wire logic [ADDR_WIDTH-1:0] CPU_ADDR,
  input  wire logic [DATA_WIDTH-1:0] CPU_DATA_OUT,
  input  wire io_exp_pkg::cpu_ctl_s  CPU_CTL,
  output logic      [DATA_WIDTH-1:0] CPU_DATA_IN,
  output logic                       CPU_DATA_VALID,
  output logic                       CPU_WAIT_N,
  output logic                       CPU_INT_N,
  // connector side
  output logic      [ADDR_WIDTH-1:0] BUS_ADDR,
  output logic                       BUS_ADDR_OE,
  input  wire logic [DATA_WIDTH-1:0] BUS_DATA_I,
  output logic      [DATA_WIDTH-1:0] BUS_DATA_O,
  output logic                       BUS_DATA_OE,
  output io_exp_pkg::bus_ctl_s       BUS_CTL,
  output logic                       BUS_CTL_OE,
  output logic                       BUS_RESET_N,
  input  wire logic                  PERIPHERAL_SELECT_ACK_N,
  input  wire logic                  BUS_WAIT_REQUEST_N,
  input  wire logic                  BUS_INTERRUPT_REQUEST_N
);

  ////////////////////////////////////////////////////////////////////////
  // connector inputs through two flip-flops

  logic [2:0] pin_sync;

  io_exp_sync #(
    .WIDTH (3)
  ) u_sync (
    .CLOCK (CLOCK),
    .SRST  (SRST),
    .D     ({PERIPHERAL_SELECT_ACK_N,
             BUS_WAIT_REQUEST_N,
             BUS_INTERRUPT_REQUEST_N}),
    .Q     (pin_sync)
  );

  logic select_ack_n;
  logic wait_req_n;
  logic int_req_n;

  assign select_ack_n = pin_sync[2];
  assign wait_req_n   = pin_sync[1];
  assign int_req_n    = pin_sync[0];

  logic [DATA_WIDTH-1:0] bus_data_sync;

  io_exp_sync #(
    .WIDTH (DATA_WIDTH)
  ) u_data_sync (
    .CLOCK (CLOCK),
    .SRST  (SRST),
    .D     (BUS_DATA_I),
    .Q     (bus_data_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // cycle decode

  function automatic logic port_write(
    input io_exp_pkg::cpu_ctl_s c,
    input logic [ADDR_WIDTH-1:0] a,
    input logic [7:0]            p
  );
    port_write = !c.io_request_n && !c.wr_n && c.opcode_fetch_n
                 && (a[7:0] == p);
  endfunction

  function automatic logic port_read(
    input io_exp_pkg::cpu_ctl_s c,
    input logic [ADDR_WIDTH-1:0] a,
    input logic [7:0]            p
  );
    port_read = !c.io_request_n && !c.rd_n && c.opcode_fetch_n
                && (a[7:0] == p);
  endfunction

  logic io_cycle;
  logic in_cycle;
  logic out_cycle;
  logic int_ack;

  assign io_cycle  = !CPU_CTL.io_request_n;
  assign in_cycle  = io_cycle && !CPU_CTL.rd_n;
  assign out_cycle = io_cycle && !CPU_CTL.wr_n;
  assign int_ack   = io_cycle && !CPU_CTL.opcode_fetch_n;

  logic own_port;

  // reads in the reserved range stay with the host
  assign own_port = CPU_ADDR[7:0] >= io_exp_pkg::RESERVED_PORT_BASE;

  ////////////////////////////////////////////////////////////////////////
  // enable bits

  logic ext_io_enable_r;
  logic ext_io_enable_nxt;
  logic bus_int_enable_r;
  logic bus_int_enable_nxt;

  always_comb
  begin
    ext_io_enable_nxt  = ext_io_enable_r;
    bus_int_enable_nxt = bus_int_enable_r;
    // bit 4 of port 0ECH opens the bus
    if (port_write(CPU_CTL, CPU_ADDR, io_exp_pkg::EXT_IO_CTRL_PORT))
    begin
      ext_io_enable_nxt = CPU_DATA_OUT[io_exp_pkg::EXT_IO_ENABLE_POS];
    end
    if (port_write(CPU_CTL, CPU_ADDR, io_exp_pkg::INT_CTRL_PORT))
    begin
      bus_int_enable_nxt = CPU_DATA_OUT[io_exp_pkg::BUS_INT_ENABLE_POS];
    end
    if (SRST)
    begin
      ext_io_enable_nxt  = io_exp_pkg::EXT_IO_ENABLE_RST;
      bus_int_enable_nxt = io_exp_pkg::BUS_INT_ENABLE_RST;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    ext_io_enable_r  <= ext_io_enable_nxt;
    bus_int_enable_r <= bus_int_enable_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // connector drivers

  logic [ADDR_WIDTH-1:0] bus_addr_r;
  logic [ADDR_WIDTH-1:0] bus_addr_nxt;
  logic                  addr_oe_r;
  logic                  addr_oe_nxt;
  logic [DATA_WIDTH-1:0] bus_data_r;
  logic [DATA_WIDTH-1:0] bus_data_nxt;
  logic                  data_oe_r;
  logic                  data_oe_nxt;
  io_exp_pkg::bus_ctl_s  bus_ctl_r;
  io_exp_pkg::bus_ctl_s  bus_ctl_nxt;
  logic                  ctl_oe_r;
  logic                  ctl_oe_nxt;
  logic                  reset_n_r;
  logic                  reset_n_nxt;

  always_comb
  begin
    bus_addr_nxt = '0;
    addr_oe_nxt  = 1'b0;
    bus_data_nxt = '0;
    data_oe_nxt  = 1'b0;
    bus_ctl_nxt  = '1;
    ctl_oe_nxt   = 1'b0;
    // nothing but reset leaves the port while disabled
    if (ext_io_enable_r)
    begin
      // low port address onto the connector
      bus_addr_nxt = CPU_ADDR;
      addr_oe_nxt  = 1'b1;
      ctl_oe_nxt   = 1'b1;
      bus_ctl_nxt.opcode_fetch_n = CPU_CTL.opcode_fetch_n;
      // I/O request on every input or output cycle
      bus_ctl_nxt.io_request_n   = !io_cycle;
      // input strobe for the whole input cycle
      bus_ctl_nxt.in_strobe_n    = !in_cycle;
      // output strobe from request and write
      bus_ctl_nxt.out_strobe_n   = !out_cycle;
      // processor drives the data lines except on input and interrupt acknowledge cycles
      if (!in_cycle && !int_ack)
      begin
        bus_data_nxt = CPU_DATA_OUT;
        data_oe_nxt  = 1'b1;
      end
    end
    // reset always passes through
    reset_n_nxt = !SRST;
    if (SRST)
    begin
      bus_addr_nxt = '0;
      addr_oe_nxt  = 1'b0;
      bus_data_nxt = '0;
      data_oe_nxt  = 1'b0;
      bus_ctl_nxt  = '1;
      ctl_oe_nxt   = 1'b0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    bus_addr_r <= bus_addr_nxt;
    addr_oe_r  <= addr_oe_nxt;
    bus_data_r <= bus_data_nxt;
    data_oe_r  <= data_oe_nxt;
    bus_ctl_r  <= bus_ctl_nxt;
    ctl_oe_r   <= ctl_oe_nxt;
    reset_n_r  <= reset_n_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // processor side: read data, wait and interrupt

  logic [DATA_WIDTH-1:0] cpu_data_r;
  logic [DATA_WIDTH-1:0] cpu_data_nxt;
  logic                  cpu_valid_r;
  logic                  cpu_valid_nxt;
  logic                  cpu_wait_n_r;
  logic                  cpu_wait_n_nxt;
  logic                  cpu_int_n_r;
  logic                  cpu_int_n_nxt;
  logic                  select_held_r;
  logic                  select_held_nxt;

  always_comb
  begin
    cpu_data_nxt  = '0;
    cpu_valid_nxt = 1'b0;
    // live request level on port E0 whatever the enable
    if (port_read(CPU_CTL, CPU_ADDR, io_exp_pkg::INT_STATUS_PORT))
    begin
      cpu_data_nxt[io_exp_pkg::BUS_INT_STATUS_POS] = int_req_n;
      cpu_valid_nxt = 1'b1;
    end
    // select low turns the transceiver toward the processor
    else if (ext_io_enable_r && in_cycle && !own_port && !select_ack_n
             && select_held_r)
    begin
      cpu_data_nxt  = bus_data_sync;
      cpu_valid_nxt = 1'b1;
    end
    // data bits may resolve a cycle after select; wait one more sample
    select_held_nxt = !select_ack_n;
    cpu_wait_n_nxt = !(ext_io_enable_r && !wait_req_n);
    // interrupt passes only while its enable is set
    cpu_int_n_nxt  = !(bus_int_enable_r && !int_req_n);
    if (SRST)
    begin
      cpu_data_nxt   = '0;
      cpu_valid_nxt  = 1'b0;
      cpu_wait_n_nxt = 1'b1;
      cpu_int_n_nxt  = 1'b1;
      select_held_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    cpu_data_r   <= cpu_data_nxt;
    cpu_valid_r  <= cpu_valid_nxt;
    cpu_wait_n_r <= cpu_wait_n_nxt;
    cpu_int_n_r  <= cpu_int_n_nxt;
    select_held_r <= select_held_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign BUS_ADDR       = bus_addr_r;
  assign BUS_ADDR_OE    = addr_oe_r;
  assign BUS_DATA_O     = bus_data_r;
  assign BUS_DATA_OE    = data_oe_r;
  assign BUS_CTL        = bus_ctl_r;
  assign BUS_CTL_OE     = ctl_oe_r;
  assign BUS_RESET_N    = reset_n_r;
  assign CPU_DATA_IN    = cpu_data_r;
  assign CPU_DATA_VALID = cpu_valid_r;
  assign CPU_WAIT_N     = cpu_wait_n_r;
  assign CPU_INT_N      = cpu_int_n_r;

endmodule
`default_nettype wire

//--- tb/io_exp_port_asserts.sv
// checker: port timing of the I/O expansion port
// assumes: bound to io_exp_port, one clock domain
`timescale 1ns/1ns
`default_nettype none
module io_exp_port_asserts #(
  parameter int ADDR_WIDTH = 8,
  parameter int DATA_WIDTH = 8
) (
  input wire logic                  CLOCK,
  input wire logic                  SRST,
  input wire logic [ADDR_WIDTH-1:0] CPU_ADDR,
  input wire logic [DATA_WIDTH-1:0] CPU_DATA_OUT,
  input wire io_exp_pkg::cpu_ctl_s  CPU_CTL,
  input wire logic                  CPU_WAIT_N,
  input wire logic [ADDR_WIDTH-1:0] BUS_ADDR,
  input wire logic                  BUS_ADDR_OE,
  input wire logic [DATA_WIDTH-1:0] BUS_DATA_O,
  input wire logic                  BUS_DATA_OE,
  input wire io_exp_pkg::bus_ctl_s  BUS_CTL,
  input wire logic                  BUS_CTL_OE,
  input wire logic                  BUS_RESET_N,
  input wire logic                  BUS_WAIT_REQUEST_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  sequence wait_low;
    !BUS_WAIT_REQUEST_N [*4];
  endsequence
  logic enable_write_now;
  assign enable_write_now = !CPU_CTL.io_request_n && !CPU_CTL.wr_n
    && CPU_CTL.opcode_fetch_n
    && CPU_ADDR[7:0] == io_exp_pkg::EXT_IO_CTRL_PORT
    && CPU_DATA_OUT[io_exp_pkg::EXT_IO_ENABLE_POS];
  sequence enable_write;
    enable_write_now;
  endsequence
  sequence quiet_next;
    CPU_CTL.io_request_n;
  endsequence
  a_addr_mirror: assert property (
    BUS_ADDR_OE |-> BUS_ADDR == $past(CPU_ADDR))
    else $error("bus address not copied");
  a_ctl_mirror: assert property (
    BUS_CTL_OE |-> BUS_CTL.io_request_n == $past(CPU_CTL.io_request_n)
      && BUS_CTL.opcode_fetch_n == $past(CPU_CTL.opcode_fetch_n))
    else $error("bus request or fetch not copied");
  a_in_strobe: assert property (
    BUS_CTL_OE |-> BUS_CTL.in_strobe_n
      == $past(CPU_CTL.io_request_n | CPU_CTL.rd_n))
    else $error("input strobe wrong");
  a_out_strobe: assert property (
    BUS_CTL_OE |-> BUS_CTL.out_strobe_n
      == $past(CPU_CTL.io_request_n | CPU_CTL.wr_n))
    else $error("output strobe wrong");
  a_oe_group: assert property (
    !BUS_CTL_OE |-> !BUS_ADDR_OE && !BUS_DATA_OE)
    else $error("bus line driven while disabled");
  a_enable_cause: assert property (
    $rose(BUS_CTL_OE) |-> $past(enable_write_now, 2))
    else $error("bus enabled without enable write");
  a_enable_open: assert property (
    enable_write ##1 quiet_next |=> BUS_CTL_OE)
    else $error("enable write did not open the bus");
  a_data_turn: assert property (
    BUS_DATA_OE |-> BUS_CTL_OE && BUS_CTL.in_strobe_n)
    else $error("data driven during input cycle");
  a_data_mirror: assert property (
    BUS_DATA_OE |-> BUS_DATA_O == $past(CPU_DATA_OUT))
    else $error("bus data not copied");
  a_reset_pass: assert property (disable iff (1'b0)
    1 |=> BUS_RESET_N == !$past(SRST))
    else $error("bus reset does not follow system reset");
  a_wait_pass: assert property (
    (BUS_CTL_OE throughout wait_low) |-> !CPU_WAIT_N)
    else $error("bus wait not passed to processor");
endmodule
bind io_exp_port io_exp_port_asserts #(
  .ADDR_WIDTH(ADDR_WIDTH),
  .DATA_WIDTH(DATA_WIDTH)
) u_asserts (
  .CLOCK, .SRST, .CPU_ADDR, .CPU_DATA_OUT, .CPU_CTL, .CPU_WAIT_N,
  .BUS_ADDR, .BUS_ADDR_OE, .BUS_DATA_O, .BUS_DATA_OE, .BUS_CTL, .BUS_CTL_OE,
  .BUS_RESET_N, .BUS_WAIT_REQUEST_N);
`default_nettype wire

//--- tb/io_card_model.sv
// model: peripheral card on the expansion connector
// assumes: connector lines of io_exp_port, lines idle high
`timescale 1ns/1ns
`default_nettype none
module io_card_model #(
  parameter logic [7:0] CARD_ADDR = 8'h25
) (
  input  wire logic                 clock,
  input  wire logic [7:0]           bus_addr,
  input  wire logic [7:0]           bus_data_o,
  input  wire logic                 bus_data_oe,
  input  wire io_exp_pkg::bus_ctl_s bus_ctl,
  input  wire logic                 bus_ctl_oe,
  input  wire logic                 stall,
  input  wire logic                 irq,
  output logic      [7:0]           data,
  output logic                      select_n,
  output logic                      wait_n,
  output logic                      int_n
);
  logic [7:0] hold_r = 8'h00;
  logic       match;
  assign match = bus_ctl_oe && bus_addr == CARD_ADDR && CARD_ADDR < 8'h80;
  assign select_n = !(match && !bus_ctl.in_strobe_n);
  // released lines show the inverse of the last value
  assign data = select_n ? ~hold_r : hold_r;
  assign wait_n = !stall;
  assign int_n = !irq;
  always @(posedge clock)
    if (match && !bus_ctl.out_strobe_n && bus_data_oe)
      hold_r <= bus_data_o;
endmodule
`default_nettype wire

//--- tb/io_exp_port_test.sv
// bench: self-checking run of io_exp_port with a card model
// assumes: card sits at port 25H, below the host range
`timescale 1ns/1ns
`default_nettype none
module io_exp_port_test;
  localparam logic [7:0] CARD = 8'h25;
  localparam logic [3:0] IDLE = 4'hF, WR = 4'hA, RD = 4'h9, ACK = 4'h3;
  logic clock = 1'b0, srst = 1'b1, stall = 1'b0, irq = 1'b0;
  logic [7:0] cpu_addr = 8'h00, cpu_dout = 8'h00, cpu_din, bus_addr;
  logic [7:0] bus_di, bus_do, lfsr = 8'h0E;
  io_exp_pkg::cpu_ctl_s cpu_ctl = IDLE;
  io_exp_pkg::bus_ctl_s bus_ctl;
  logic valid, wait_n, int_n, addr_oe, data_oe, ctl_oe, rst_n;
  logic sel_n, bwait_n, bint_n, valid_q = 1'b0;
  logic [15:0] expect_q[$];
  logic [15:0] note;
  int errors = 0, samples_checked = 0;
  always #5 clock = ~clock;
  io_exp_port u_io_exp_port (.CLOCK(clock), .SRST(srst),
    .CPU_ADDR(cpu_addr), .CPU_DATA_OUT(cpu_dout), .CPU_CTL(cpu_ctl),
    .CPU_DATA_IN(cpu_din), .CPU_DATA_VALID(valid), .CPU_WAIT_N(wait_n),
    .CPU_INT_N(int_n), .BUS_ADDR(bus_addr), .BUS_ADDR_OE(addr_oe),
    .BUS_DATA_I(bus_di), .BUS_DATA_O(bus_do), .BUS_DATA_OE(data_oe),
    .BUS_CTL(bus_ctl), .BUS_CTL_OE(ctl_oe), .BUS_RESET_N(rst_n),
    .PERIPHERAL_SELECT_ACK_N(sel_n), .BUS_WAIT_REQUEST_N(bwait_n),
    .BUS_INTERRUPT_REQUEST_N(bint_n));
  io_card_model #(.CARD_ADDR(CARD)) u_io_card_model (.clock(clock),
    .bus_addr(bus_addr), .bus_data_o(bus_do), .bus_data_oe(data_oe),
    .bus_ctl(bus_ctl), .bus_ctl_oe(ctl_oe), .stall(stall), .irq(irq),
    .data(bus_di), .select_n(sel_n), .wait_n(bwait_n), .int_n(bint_n));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cycle(input logic [7:0] a, input logic [7:0] v,
                       input logic [3:0] c, input int n);
    tick(1);
    cpu_addr = a;
    cpu_dout = v;
    cpu_ctl = c;
    tick(n);
    cpu_ctl = IDLE;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] v);
    expect_q.push_back({m, v});
    cycle(a, 8'h00, RD, 8);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    if (valid === 1'b1 && !valid_q)
    begin
      if (expect_q.size() == 0)
      begin
        errors++;
        $display("Error read data expected none seen %h", cpu_din);
      end
      else
      begin
        note = expect_q.pop_front();
        check("read data", cpu_din & note[15:8], note[7:0]);
      end
    end
    valid_q <= valid;
  end
  initial
  begin
    #20000;
    errors++;
    summarize();
  end
  initial
  begin
    tick(6);
    srst = 1'b0;
    tick(1);
    check("enables", {5'h00, ctl_oe, addr_oe, rst_n}, 8'h01);
    irq = 1'b1;
    stall = 1'b1;
    tick(6);
    check("wait and int", {6'h00, wait_n, int_n}, 8'h03);
    stall = 1'b0;
    rd(8'hE0, 8'h08, 8'h00);
    cycle(8'hE0, 8'h08, WR, 1);
    tick(5);
    check("int on", {7'h00, int_n}, 8'h00);
    irq = 1'b0;
    tick(5);
    check("int off", {7'h00, int_n}, 8'h01);
    rd(8'hE0, 8'h08, 8'h08);
    cycle(8'hEC, 8'h10, WR, 1);
    stall = 1'b1;
    tick(6);
    check("wait on", {7'h00, wait_n}, 8'h00);
    stall = 1'b0;
    tick(5);
    check("wait off", {7'h00, wait_n}, 8'h01);
    cycle(CARD, 8'h00, ACK, 1);
    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      cycle(CARD, lfsr, WR, 2);
      rd(CARD, 8'hFF, lfsr);
    end
    tick(4);
    check("pending reads", 8'(expect_q.size()), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
